// ==== verilog/sio_pkg.sv ====
// Constants and carrier types for the serial interface options register.
package sio_pkg;

    // ========================================================================
    // Serial frame layout
    // ========================================================================
    localparam int          SIO_CMD_BITS    = 8;
    localparam int          SIO_ADDR_W      = 6;
    localparam int          SIO_CNT_W       = 6;
    localparam int          SIO_CMD_WEN_BIT = 7;   // Must be 0 for a command
    localparam int          SIO_CMD_RD_BIT  = 6;   // 1 read, 0 write
    localparam int          SIO_SHOUT_W     = 24;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [5:0]  SIO_ADDR_OPTIONS  = 6'h02;
    localparam logic [5:0]  SIO_ADDR_CHECKSUM = 6'h03;
    localparam int          SIO_OPT_W         = 16;
    localparam int          SIO_CHK_W         = 24;
    localparam logic [15:0] SIO_OPT_RESET     = 16'h0000;
    localparam logic [15:0] SIO_OPT_WMASK     = 16'h19e0; // Writable bits
    localparam logic [23:0] SIO_CHK_ZERO      = 24'h000000;
    localparam logic [7:0]  SIO_PAD_BYTE      = 8'h00;

    // ========================================================================
    // Options register fields
    // ========================================================================
    localparam int SIO_BIT_ALT_GATE   = 12;
    localparam int SIO_BIT_DRIVE      = 11;
    localparam int SIO_BIT_LINE_RST   = 8;
    localparam int SIO_BIT_CONT_READ  = 7;
    localparam int SIO_BIT_APPEND     = 6;
    localparam int SIO_BIT_MON_EN     = 5;

    // Port state machine, Gray coded along idle-command-data
    typedef enum logic [1:0] {
        SIO_IDLE = 2'b00,
        SIO_CMD  = 2'b01,
        SIO_DATA = 2'b11,
        SIO_SKIP = 2'b10
    } sio_state_t;

    // Decoded option enables handed to the rest of the converter
    typedef struct packed {
        logic alternate_gate_behaviour;
        logic output_drive_boost;
        logic output_line_reset_enable;
        logic continuous_result_read;
        logic append_status_to_result;
        logic integrity_monitor_enable;
    } sio_opts_t;

    // Serial pins as seen by the device
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } sio_pins_t;

endpackage : sio_pkg

// ==== verilog/sio_sync.sv ====
// Two-flop synchroniser with edge detection for the serial pins.
`timescale 1ns/1ps

module sio_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] i_async,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // Read by the second stage only
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sio_sync_state_t;

    sio_sync_state_t s_reg;
    sio_sync_state_t s_next;

    initial begin
        if (WIDTH < 1) begin
            $error("sio_sync: WIDTH must be at least 1");
        end
    end

    // Shift chain
    always_comb begin
        s_next      = s_reg;
        s_next.meta = i_async;
        s_next.sync = s_reg.meta;
        s_next.prev = s_reg.sync;
    end

    // Reset to all ones: idle serial lines sit high
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '{default: '1};
        end else begin
            s_reg <= s_next;
        end
    end

    // Edges come from stage two and three, never from the first flop
    assign o_level = s_reg.sync;
    assign o_rise  = s_reg.sync & ~s_reg.prev;
    assign o_fall  = ~s_reg.sync & s_reg.prev;

endmodule : sio_sync

// ==== verilog/sio_options.sv ====
// Serial interface options register with its port and integrity monitor.
`timescale 1ns/1ps

// Overview of operation
// - Options register, 16 bits at address 0x02, resets to all zeros.
// - Bits 15:13, 10:9 and 4:0 read zero; host writes zero there.
// - Bit 12 selects the alternate conversion-gate pin behaviour.
// - Bit 11 raises drive strength of the serial output pin.
// - Bit 8 enables serial output line reset, reset value zero.
// - Bit 7 selects continuous reading of the result register.
// - Bit 6 appends status contents to every result read.
// - With bit 5 set, a monitored register change sets the fault flag.
// - Writing 0 to bit 5 clears the fault and stops monitoring.
// - Options, result and status registers are not monitored.
// - A 24-bit checksum (the monitored word itself) is readable, zero while monitoring is off.
module sio_options (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // Serial port pins
    input  wire logic                   i_sclk,
    input  wire logic                   i_cs_n,
    input  wire logic                   i_din,
    output logic                        o_dout,
    output logic                        o_dout_oe_n,
    // Monitored register contents from the rest of the device
    input  wire logic [23:0]            i_mon_word,
    input  wire logic                   i_mon_update,
    // Option enables and monitor results
    output sio_pkg::sio_opts_t          o_opts,
    output logic                        o_integrity_fault_flag,
    output logic [23:0]                 o_register_checksum
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        sio_pkg::sio_state_t  state;
        logic [5:0]           bit_cnt;
        logic [7:0]           cmd;
        logic [15:0]          shin;
        logic [23:0]          shout;
        logic                 dout;
        logic [15:0]          opts;
        logic [23:0]          mon_ref;
        logic [23:0]          checksum;
        logic                 fault;
    } sio_opt_state_t;

    localparam logic [5:0] CNT_CMD_LAST =
        6'(sio_pkg::SIO_CMD_BITS - 1);
    localparam logic [5:0] CNT_WR_LAST  =
        6'(sio_pkg::SIO_CMD_BITS + sio_pkg::SIO_OPT_W - 1);
    localparam logic [5:0] CNT_MAX      = 6'h3f;

    // Register contents after reset; options and checksum start at zero
    localparam sio_opt_state_t ST_RESET = '{
        state:    sio_pkg::SIO_IDLE,
        bit_cnt:  6'h00,
        cmd:      8'h00,
        shin:     16'h0000,
        shout:    24'h000000,
        dout:     1'b0,
        opts:     sio_pkg::SIO_OPT_RESET,
        mon_ref:  24'h000000,
        checksum: sio_pkg::SIO_CHK_ZERO,
        fault:    1'b0
    };

    sio_opt_state_t s_reg;
    sio_opt_state_t s_next;

    sio_pkg::sio_pins_t pin_level;
    sio_pkg::sio_pins_t pin_rise;
    sio_pkg::sio_pins_t pin_fall;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    sio_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_sclk, i_cs_n, i_din}),
        .o_level   (pin_level),
        .o_rise    (pin_rise),
        .o_fall    (pin_fall)
    );

    // ========================================================================
    // Read data, left aligned so the first bit leaves from the top
    // ========================================================================
    function automatic logic [23:0] read_word(
        input logic [5:0]  addr,
        input logic [15:0] opts,
        input logic [23:0] checksum
    );
        logic [23:0] w;
        w = sio_pkg::SIO_CHK_ZERO;
        if (addr == sio_pkg::SIO_ADDR_OPTIONS) begin
            w = {opts & sio_pkg::SIO_OPT_WMASK, sio_pkg::SIO_PAD_BYTE};
        end else if (addr == sio_pkg::SIO_ADDR_CHECKSUM) begin
            w = checksum;
        end
        return w;
    endfunction : read_word

    // Saturating bit counter step, shared by both frame phases
    function automatic logic [5:0] cnt_step(input logic [5:0] c);
        return (c == CNT_MAX) ? c : 6'(c + 6'h01);
    endfunction : cnt_step

    // Command decode, shared by the shift, write and enable paths
    function automatic logic is_read(input logic [7:0] cmd);
        return cmd[sio_pkg::SIO_CMD_RD_BIT];
    endfunction : is_read

    function automatic logic is_opt_write(input logic [7:0] cmd);
        return !cmd[sio_pkg::SIO_CMD_RD_BIT] &&
               (cmd[5:0] == sio_pkg::SIO_ADDR_OPTIONS);
    endfunction : is_opt_write

    // Monitored contents differ from the reference on an update
    function automatic logic mon_mismatch(
        input logic        armed,
        input logic        update,
        input logic [23:0] word,
        input logic [23:0] ref_word
    );
        return armed && update && (word != ref_word);
    endfunction : mon_mismatch

    // ========================================================================
    // Elaboration checks
    // ========================================================================
    // Frame lengths must fit the saturating bit counter
    initial begin
        if (sio_pkg::SIO_CMD_BITS + sio_pkg::SIO_SHOUT_W >= 64) begin
            $error("sio_options: frame longer than the bit counter");
        end
        if (sio_pkg::SIO_OPT_W + 8 > sio_pkg::SIO_SHOUT_W) begin
            $error("sio_options: options word wider than read shifter");
        end
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        logic [7:0]  cmd_v;
        logic [15:0] wr_v;
        logic        en_old;
        logic        en_new;
        cmd_v  = '0;
        wr_v   = '0;
        en_old = 1'b0;
        en_new = 1'b0;
        s_next = s_reg;

        // Frame logic: sample on rising link edge, shift on falling edge
        if (pin_level.cs_n) begin
            s_next.state   = sio_pkg::SIO_IDLE;
            s_next.bit_cnt = '0;
            s_next.dout    = 1'b0;
        end else begin
            case (s_reg.state)
                sio_pkg::SIO_IDLE: begin
                    s_next.state   = sio_pkg::SIO_CMD;
                    s_next.bit_cnt = '0;
                end
                sio_pkg::SIO_CMD: begin
                    if (pin_rise.sclk) begin
                        cmd_v          = {s_reg.cmd[6:0], pin_level.din};
                        s_next.cmd     = cmd_v;
                        s_next.bit_cnt = cnt_step(s_reg.bit_cnt);
                        if (s_reg.bit_cnt == CNT_CMD_LAST) begin
                            if (cmd_v[sio_pkg::SIO_CMD_WEN_BIT]) begin
                                s_next.state = sio_pkg::SIO_SKIP;
                            end else begin
                                s_next.state = sio_pkg::SIO_DATA;
                                s_next.shout = read_word(
                                    cmd_v[5:0], s_reg.opts,
                                    s_reg.checksum);
                            end
                        end
                    end
                end
                sio_pkg::SIO_DATA: begin
                    if (pin_rise.sclk) begin
                        wr_v           = {s_reg.shin[14:0], pin_level.din};
                        s_next.shin    = wr_v;
                        s_next.bit_cnt = cnt_step(s_reg.bit_cnt);
                        // Options write lands on the sixteenth data bit
                        if (is_opt_write(s_reg.cmd) &&
                            s_reg.bit_cnt == CNT_WR_LAST) begin
                            // Reserved bits stay zero whatever is sent
                            s_next.opts = wr_v &
                                sio_pkg::SIO_OPT_WMASK;
                        end
                    end
                    // Falling link edge: next read bit goes to the pin
                    if (pin_fall.sclk && is_read(s_reg.cmd)) begin
                        s_next.dout  = s_reg.shout[sio_pkg::SIO_SHOUT_W-1];
                        s_next.shout = {s_reg.shout[22:0], 1'b0};
                    end
                end
                sio_pkg::SIO_SKIP: begin
                    // Bad command: ignore the rest of the frame
                    s_next.state = sio_pkg::SIO_SKIP;
                end
                default: begin
                    s_next.state = sio_pkg::SIO_IDLE;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Integrity monitor, fed by the options after this cycle's write
        // --------------------------------------------------------------------
        en_old = s_reg.opts[sio_pkg::SIO_BIT_MON_EN];
        en_new = s_next.opts[sio_pkg::SIO_BIT_MON_EN];

        // Reference taken as monitoring starts; host set up the rest first
        if (en_new && !en_old) begin
            s_next.mon_ref = i_mon_word;
        end

        // Clear only while monitoring is off, so no set is ever lost.
        // The watched word excludes options, result and status contents.
        if (!en_new) begin
            s_next.fault = 1'b0;
        end else if (mon_mismatch(en_old, i_mon_update, i_mon_word,
                                  s_reg.mon_ref)) begin
            s_next.fault = 1'b1;
        end

        // Checksum reads as zero whenever monitoring is off
        if (en_new) begin
            s_next.checksum = i_mon_word;
        end else begin
            s_next.checksum = sio_pkg::SIO_CHK_ZERO;
        end
    end

    // ========================================================================
    // State register
    // ========================================================================
    // Asynchronous reset loads constants only
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Pin driven only while a read frame is shifting data; the enable is
    // decoded from flops, so it cannot glitch on a half-seen command
    assign o_dout      = s_reg.dout;
    assign o_dout_oe_n = !((s_reg.state == sio_pkg::SIO_DATA) &&
                           is_read(s_reg.cmd));

    // Option enables straight from the register bits
    assign o_opts.alternate_gate_behaviour =
        s_reg.opts[sio_pkg::SIO_BIT_ALT_GATE];
    assign o_opts.output_drive_boost =
        s_reg.opts[sio_pkg::SIO_BIT_DRIVE];
    assign o_opts.output_line_reset_enable =
        s_reg.opts[sio_pkg::SIO_BIT_LINE_RST];
    assign o_opts.continuous_result_read =
        s_reg.opts[sio_pkg::SIO_BIT_CONT_READ];
    assign o_opts.append_status_to_result =
        s_reg.opts[sio_pkg::SIO_BIT_APPEND];
    assign o_opts.integrity_monitor_enable =
        s_reg.opts[sio_pkg::SIO_BIT_MON_EN];

    // Monitor results, both registered
    assign o_integrity_fault_flag = s_reg.fault;
    assign o_register_checksum    = s_reg.checksum;

endmodule : sio_options

// ==== tb/sio_options_assertions.sv ====
// Port checker for the options block.
`timescale 1ns/1ps

module sio_options_assertions (
    // Clock and reset
    input wire logic               i_clk_sys,
    input wire logic               i_rst,
    // Watched ports
    input wire logic               i_cs_n,
    input wire logic               o_dout_oe_n,
    input wire logic               i_mon_update,
    input wire sio_pkg::sio_opts_t o_opts,
    input wire logic               o_integrity_fault_flag,
    input wire logic [23:0]        o_register_checksum
);
    // ========================================================================
    // Properties
    // ========================================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire en = o_opts.integrity_monitor_enable;
    wire flt = o_integrity_fault_flag;
    // Two cycles off leaves room for one register stage
    sequence s_off; !en ##1 !en; endsequence
    sequence s_idle; i_cs_n [*4]; endsequence

    a_reset_zero: assert property (disable iff (1'b0)
        i_rst |-> o_opts == '0) else $error("options not cleared");
    a_sum_off: assert property (
        s_off |-> o_register_checksum == 24'h000000)
        else $error("checksum not zero while off");
    a_fault_clear: assert property (
        s_off |-> !flt) else $error("fault kept while off");
    a_fault_en: assert property (
        $rose(flt) |-> $past(en)) else $error("fault without monitor");
    a_fault_cause: assert property (
        $rose(flt) |-> ($past(i_mon_update) || $past(i_mon_update, 2)
        || $past(i_mon_update, 3))) else $error("fault without update");
    a_fault_hold: assert property (
        $fell(flt) |-> !en || !$past(en)) else $error("fault dropped");
    a_mon_start: assert property (
        s_off ##1 en |-> !flt) else $error("fault at monitor start");
    a_port_idle: assert property (
        s_idle |-> o_dout_oe_n) else $error("output driven while idle");
endmodule : sio_options_assertions

bind sio_options sio_options_assertions i_sio_options_assertions (
    .i_clk_sys, .i_rst, .i_cs_n, .o_dout_oe_n, .i_mon_update, .o_opts,
    .o_integrity_fault_flag, .o_register_checksum);

// ==== tb/sio_host.sv ====
// Serial host model: MSB-first frames, clock idles high.
`timescale 1ns/1ps

module sio_host (
    // Serial pins
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    input  wire logic i_dout,
    input  wire logic i_dout_oe_n
);
    logic last;
    // Released line shows the inverse, never a stale bit
    wire  line = i_dout_oe_n ? ~last : i_dout;

    // ========================================================================
    // Frame task
    // ========================================================================
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
        last   = 1'b0;
    end
    // Command byte then n data bits; clock stands still outside frames
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int n, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd << (24 - n)};
        rd = 24'h000000;
        o_cs_n = 1'b0;
        #62.5;
        for (int k = 0; k < 8 + n; k++) begin
            o_sclk = 1'b0;
            o_din  = (k < 8 || !cmd[6]) ? sh[31-k] : ~o_din;
            #62.5;
            if (k >= 8) rd = {rd[22:0], line};
            last   = line;
            o_sclk = 1'b1;
            #62.5;
        end
        o_cs_n = 1'b1;
        #250;
    endtask : xfer
endmodule : sio_host

// ==== tb/serial_interface_options_register_checksum_bench.sv ====
// Self-checking bench for the options register block.
`timescale 1ns/1ps

module serial_interface_options_register_checksum_bench;
    logic               clk = 1'b0;
    logic               rst;
    logic [23:0]        mon_word = 24'h000000;
    logic               mon_upd = 1'b0;
    logic               sclk, cs_n, din, dout, dout_oe_n, fault;
    sio_pkg::sio_opts_t opts;
    logic [23:0]        chk, rd;
    int                 failures = 0;
    int                 checks = 0;

    always #5 clk = ~clk;
    sio_options i_sio_options (.i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .o_dout(dout),
        .o_dout_oe_n(dout_oe_n), .i_mon_word(mon_word),
        .i_mon_update(mon_upd), .o_opts(opts),
        .o_integrity_fault_flag(fault), .o_register_checksum(chk));
    sio_host i_sio_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
        .i_dout(dout), .i_dout_oe_n(dout_oe_n));

    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic cmp(input string what, input logic [23:0] exp, got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] v);
        i_sio_host.xfer({2'b00, sio_pkg::SIO_ADDR_OPTIONS}, {8'h00, v}, 16, rd);
    endtask : wr
    task automatic rdreg(input logic [5:0] a, input int n);
        i_sio_host.xfer({2'b01, a}, 24'h000000, n, rd);
    endtask : rdreg
    // One update pulse, then time for the compare to land
    task automatic upd(input logic [23:0] w);
        @(posedge clk) #1 mon_word = w;
        mon_upd = 1'b1;
        @(posedge clk) #1 mon_upd = 1'b0;
        repeat (4) @(posedge clk);
    endtask : upd

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_fields();
        logic [15:0] b;
        rdreg(sio_pkg::SIO_ADDR_OPTIONS, 16);
        cmp("options reset", 24'h000000, rd);
        // Every bit alone, reserved ones included on purpose
        for (int k = 0; k < 16; k++) begin
            b = 16'h0001 << k;
            wr(b);
            rdreg(sio_pkg::SIO_ADDR_OPTIONS, 16);
            cmp("options", {8'h00, b & sio_pkg::SIO_OPT_WMASK}, rd);
            cmp("enables", {18'h0, b[12], b[11], b[8:5]}, {18'h0, opts});
        end
        wr(16'h0000);
        $display("test fields done");
    endtask : t_fields
    task automatic t_monitor();
        upd(24'h5a5a5a);
        cmp("fault off", 24'h0, {23'h0, fault});
        cmp("checksum off", 24'h0, chk);
        rdreg(sio_pkg::SIO_ADDR_CHECKSUM, 24);
        cmp("checksum read", 24'h0, rd);
        wr(16'h0020);
        cmp("checksum on", 24'h5a5a5a, chk);
        rdreg(sio_pkg::SIO_ADDR_CHECKSUM, 24);
        cmp("checksum on read", 24'h5a5a5a, rd);
        upd(24'h5a5a5a);
        cmp("fault same", 24'h0, {23'h0, fault});
        wr(16'h0060);
        cmp("fault options", 24'h0, {23'h0, fault});
        upd(24'h5a5a5b);
        cmp("fault change", 24'h1, {23'h0, fault});
        wr(16'h0000);
        cmp("fault clear", 24'h0, {23'h0, fault});
        cmp("checksum clear", 24'h0, chk);
        $display("test monitor done");
    endtask : t_monitor

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    initial begin
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_fields();
        t_monitor();
        results();
    end
    // Cuts a hang short
    initial begin
        #1000000;
        failures++;
        results();
    end
endmodule : serial_interface_options_register_checksum_bench
